// file: rtl/mtc_consts.svh
// constants of the timer common control block
// Operation
// - run bits hold or count channels 0-4
// - run register resets e0; bits 7-5 read one
// - sync register 8 bits, resets e0
// - sync bits 7-5 read one, ignore writes
// - sync bit joins channel in joint clear
// - mode register resets 80, bit7 reads one
// - quadrature bit makes channel 2 up/down
// - count every edge of both phases
// - quadrature ignores clock source, edge select
// - clearing, compare, flags stay active
// - flag condition 0 sets on both wraps
// - flag condition 1 sets on overflow only
// - pulse mode bit makes pin a PWM
// - compare a sets, compare b clears
// - combination code overrides channels 3,4 pulse bits; code masks only their pin PWM, timer_pin_a_oe still follows mode[4:3]
// - codes 10, 11 combined; 00 normal
`ifndef MTC_CONSTS_SVH
`define MTC_CONSTS_SVH
`define MTC_ADDR_RUN 12'h000
`define MTC_ADDR_SYNC 12'h004
`define MTC_ADDR_MODE 12'h008
`define MTC_ADDR_STAT 12'h00c
`define MTC_ADDR_MASK 12'h010
`define MTC_ADDR_CNT2 12'h014
`define MTC_ADDR_COMB 12'h018
`define MTC_RUN_RST 8'he0
`define MTC_SYNC_RST 8'he0
`define MTC_MODE_RST 8'h80
`define MTC_FIX_RUN 8'he0
`define MTC_FIX_SYNC 8'he0
`define MTC_FIX_MODE 8'h80
`define MTC_BIT_QUAD 6
`define MTC_BIT_OVERFLOW_FLAG_CONDITION 5
`define MTC_NCH 5
`define MTC_ST_OVF 0
`define MTC_ST_UNF 1
`endif

// file: rtl/mtc_pkg.sv
// types of the timer common control block
package mtc_pkg;
   typedef enum logic [2:0] {
      MTC_COMB_NORMAL = 3'b001,
      MTC_COMB_COMPL = 3'b010,
      MTC_COMB_RSYNC = 3'b100
   } mtc_comb_type;
   typedef struct packed {
      logic [7:0] run;
      logic [7:0] sync;
      logic [7:0] mode;
      logic [1:0] comb;
      logic [1:0] stat;
      logic [1:0] mask;
      logic [15:0] cnt2;
      logic pa;
      logic pb;
      logic [4:0] pwm;
      logic [31:0] prdata;
      logic pready;
      logic irq;
      logic wrap_flag;
      logic [4:0] clr_out;
   } mtc_state_type;
endpackage

// file: rtl/mtc_top.sv
// common control of a five-channel timer: run, sync, mode registers and channel 2 phase counter
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "mtc_consts.svh"
module mtc_top
   import mtc_pkg::*;
(
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // standby entry
   input wire logic standby,
   // channel events from per-channel logic
   input wire logic [4:0] clear_req,
   input wire logic [4:0] match_a,
   input wire logic [4:0] match_b,
   input wire logic [4:0] ch_tick,
   // phase inputs
   input wire logic phase_input_a,
   input wire logic phase_input_b,
   // channel control outputs
   output logic [4:0] count_enable,
   output logic [4:0] clear_out,
   output logic [4:0] timer_pin_a,
   output logic [4:0] timer_pin_a_oe,
   output logic [15:0] counter_ch2,
   output logic wrap_flag,
   output logic irq
);
   mtc_state_type s_q, s_d;
   logic acc, wr, rd;
   logic up, dn, ea, eb;
   logic [4:0] pwm_en;
   logic [4:0] jclr;
   mtc_comb_type comb_mode;
   logic [1:0] ev;

   assign acc = psel && penable;
   assign wr = acc && pwrite;
   assign rd = acc && !pwrite;
   assign ea = phase_input_a ^ s_q.pa;
   assign eb = phase_input_b ^ s_q.pb;

   always_comb begin
      case (s_q.comb)
         2'b10: comb_mode = MTC_COMB_COMPL;
         2'b11: comb_mode = MTC_COMB_RSYNC;
         default: comb_mode = MTC_COMB_NORMAL;
      endcase
   end

   always_comb begin
      up = (ea && phase_input_a && phase_input_b) || (eb && phase_input_b && !phase_input_a)
         || (ea && !phase_input_a && !phase_input_b) || (eb && !phase_input_b && phase_input_a);
      dn = (ea || eb) && !up;
   end

   genvar g;
   generate
      for (g = 0; g < `MTC_NCH; g = g + 1) begin : g_ch
         if (g >= 3) begin : g_hi
            assign pwm_en[g] = s_q.mode[g] && (comb_mode == MTC_COMB_NORMAL);
         end else begin : g_lo
            assign pwm_en[g] = s_q.mode[g];
         end
         assign jclr[g] = s_q.sync[g] ? |(clear_req & s_q.sync[4:0]) : clear_req[g];
      end
   endgenerate

   always_comb begin
      s_d = s_q;
      ev = 2'b00;
      s_d.pready = acc && !s_q.pready;
      s_d.pa = phase_input_a;
      s_d.pb = phase_input_b;
      // a write lands only at the edge where pready is sampled high
      if (wr && s_q.pready) begin
         case (paddr)
            `MTC_ADDR_RUN: s_d.run = pwdata[7:0] | `MTC_FIX_RUN;
            `MTC_ADDR_SYNC: s_d.sync = pwdata[7:0] | `MTC_FIX_SYNC;
            `MTC_ADDR_MODE: s_d.mode = pwdata[7:0] | `MTC_FIX_MODE;
            `MTC_ADDR_MASK: s_d.mask = pwdata[1:0];
            `MTC_ADDR_COMB: s_d.comb = pwdata[5:4];
            default: s_d.mask = s_q.mask;
         endcase
      end
      if (s_q.mode[`MTC_BIT_QUAD]) begin
         if (s_q.run[2] && up) begin
            s_d.cnt2 = s_q.cnt2 + 16'h0001;
            ev[`MTC_ST_OVF] = (s_q.cnt2 == 16'hffff);
         end else if (s_q.run[2] && dn) begin
            s_d.cnt2 = s_q.cnt2 - 16'h0001;
            ev[`MTC_ST_UNF] = (s_q.cnt2 == 16'h0000);
         end
      end else if (s_q.run[2] && ch_tick[2]) begin
         s_d.cnt2 = s_q.cnt2 + 16'h0001;
         ev[`MTC_ST_OVF] = (s_q.cnt2 == 16'hffff);
      end
      if (jclr[2]) begin
         s_d.cnt2 = 16'h0000;
      end
      s_d.wrap_flag = ev[`MTC_ST_OVF] || (ev[`MTC_ST_UNF] && !s_q.mode[`MTC_BIT_OVERFLOW_FLAG_CONDITION]);
      s_d.prdata = 32'h00000000;
      if (rd && !s_q.pready) begin
         case (paddr)
            `MTC_ADDR_RUN: s_d.prdata = {24'h000000, s_q.run};
            `MTC_ADDR_SYNC: s_d.prdata = {24'h000000, s_q.sync};
            `MTC_ADDR_MODE: s_d.prdata = {24'h000000, s_q.mode};
            `MTC_ADDR_STAT: s_d.prdata = {30'h00000000, s_q.stat};
            `MTC_ADDR_MASK: s_d.prdata = {30'h00000000, s_q.mask};
            `MTC_ADDR_CNT2: s_d.prdata = {16'h0000, s_q.cnt2};
            `MTC_ADDR_COMB: s_d.prdata = {26'h0000000, s_q.comb, 4'h0};
            default: s_d.prdata = 32'h00000000;
         endcase
      end
      // read clears status, new event wins
      if (rd && !s_q.pready && paddr == `MTC_ADDR_STAT) begin
         s_d.stat = 2'b00;
      end
      s_d.stat = s_d.stat | ev;
      s_d.irq = |(s_d.stat & s_d.mask);
      s_d.clr_out = jclr;
      // pin as pwm; a sets, b clears
      for (int i = 0; i < `MTC_NCH; i++) begin
         if (pwm_en[i] && match_b[i]) begin
            s_d.pwm[i] = 1'b0;
         end else if (pwm_en[i] && match_a[i]) begin
            s_d.pwm[i] = 1'b1;
         end
      end
      if (standby) begin
         s_d.run = `MTC_RUN_RST;
         s_d.sync = `MTC_SYNC_RST;
         s_d.mode = `MTC_MODE_RST;
         s_d.comb = 2'b00;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         s_q.run <= `MTC_RUN_RST;
         s_q.sync <= `MTC_SYNC_RST;
         s_q.mode <= `MTC_MODE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign count_enable = s_q.run[4:0];
   assign clear_out = s_q.clr_out;
   assign timer_pin_a = s_q.pwm;
   assign timer_pin_a_oe = s_q.mode[4:0];
   assign counter_ch2 = s_q.cnt2;
   assign wrap_flag = s_q.wrap_flag;
   assign irq = s_q.irq;
   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = 1'b0;

   property p_fixed_bits;
      @(posedge pclk) disable iff (!presetn) s_q.sync[7:5] == 3'b111 && s_q.mode[7] && s_q.run[7:5] == 3'b111;
   endproperty
   a_fixed_bits: assert property (p_fixed_bits) else $error("fixed bits not one");
   property p_standby;
      @(posedge pclk) disable iff (!presetn) standby |=> s_q.sync == 8'he0 && s_q.mode == 8'h80 && s_q.run == 8'he0;
   endproperty
   a_standby: assert property (p_standby) else $error("standby reload wrong");
   property p_hold;
      @(posedge pclk) disable iff (!presetn) (!s_q.run[2] && !jclr[2]) |=> $stable(s_q.cnt2);
   endproperty
   a_hold: assert property (p_hold) else $error("halted counter moved");
   property p_up;
      @(posedge pclk) disable iff (!presetn) (s_q.mode[6] && s_q.run[2] && up && !jclr[2]) |=> s_q.cnt2 == $past(s_q.cnt2) + 16'h0001;
   endproperty
   a_up: assert property (p_up) else $error("phase up count wrong");
   property p_dn;
      @(posedge pclk) disable iff (!presetn) (s_q.mode[6] && s_q.run[2] && dn && !jclr[2]) |=> s_q.cnt2 == $past(s_q.cnt2) - 16'h0001;
   endproperty
   a_dn: assert property (p_dn) else $error("phase down count wrong");
   property p_overflow_flag_condition;
      @(posedge pclk) disable iff (!presetn) (s_q.mode[5] && ev[1] && !ev[0]) |=> !wrap_flag;
   endproperty
   a_overflow_flag_condition: assert property (p_overflow_flag_condition) else $error("underflow flagged");
   property p_unf;
      @(posedge pclk) disable iff (!presetn) (!s_q.mode[5] && ev[1]) |=> wrap_flag;
   endproperty
   a_unf: assert property (p_unf) else $error("underflow not flagged");
   property p_pwm_set;
      @(posedge pclk) disable iff (!presetn) (pwm_en[0] && match_a[0] && !match_b[0]) |=> timer_pin_a[0];
   endproperty
   a_pwm_set: assert property (p_pwm_set) else $error("pwm not set");
   property p_comb;
      @(posedge pclk) disable iff (!presetn) (s_q.comb[1] && match_a[3]) |=> $stable(timer_pin_a[3]);
   endproperty
   a_comb: assert property (p_comb) else $error("pwm bit not overridden");
endmodule
`default_nettype wire

// file: dv/mtc_enc.sv
// quadrature encoder model driving the two phase inputs
`timescale 1ns/1ps
`default_nettype none
module mtc_enc (
   // clock
   input wire logic clk,
   // phase levels
   output logic a,
   output logic b
);
   logic [1:0] st = 2'b00;
   assign a = st[1];
   assign b = st[0];
   // one edge per step; order 00 01 11 10 is forward
   task automatic step(input logic up);
      @(posedge clk);
      st <= up ? {st[0], ~st[1]} : {~st[0], st[1]};
      repeat (4) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// file: dv/tb.sv
// self-checking testbench of the timer common control block
`timescale 1ns/1ps
`default_nettype none
`include "mtc_consts.svh"
module tb;
   import mtc_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, standby = 0, seen = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, wrap_flag, irq, pa, pb;
   logic [4:0] clear_req = 5'h00, match_a = 5'h00, match_b = 5'h00, ch_tick = 5'h00;
   logic [4:0] count_enable, clear_out, timer_pin_a, timer_pin_a_oe;
   logic [15:0] counter_ch2;
   int failures = 0, n_tests = 0;
   always #2 pclk = ~pclk;
   always @(posedge pclk) if (wrap_flag === 1'b1) seen <= 1'b1;
   mtc_enc mtc_enc_i (.clk(pclk), .a(pa), .b(pb));
   mtc_top mtc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .standby(standby), .clear_req(clear_req), .match_a(match_a), .match_b(match_b), .ch_tick(ch_tick),
      .phase_input_a(pa), .phase_input_b(pb), .count_enable(count_enable), .clear_out(clear_out),
      .timer_pin_a(timer_pin_a), .timer_pin_a_oe(timer_pin_a_oe), .counter_ch2(counter_ch2),
      .wrap_flag(wrap_flag), .irq(irq));
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(negedge pclk);
      while (pready !== 1'b1 && n < 16) begin
         @(negedge pclk);
         n++;
      end
      if (n == 16) failures++;
      rd = prdata;
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rdchk(input string s, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(s, e, rd);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic t_regs;
      rdchk("run", `MTC_ADDR_RUN, 32'he0);
      rdchk("sync", `MTC_ADDR_SYNC, 32'he0);
      rdchk("mode", `MTC_ADDR_MODE, 32'h80);
      apb(1'b1, `MTC_ADDR_SYNC, 32'h00);
      rdchk("sync fixed", `MTC_ADDR_SYNC, 32'he0);
      apb(1'b1, `MTC_ADDR_MODE, 32'h00);
      rdchk("mode fixed", `MTC_ADDR_MODE, 32'h80);
      apb(1'b1, `MTC_ADDR_RUN, 32'h1a);
      chk("count_enable", 32'h1a, count_enable);
      rdchk("unmapped", 12'hffc, 32'h0);
      apb(1'b1, `MTC_ADDR_SYNC, 32'h1f);
      standby <= 1'b1;
      @(posedge pclk);
      standby <= 1'b0;
      rdchk("run standby", `MTC_ADDR_RUN, 32'he0);
      rdchk("sync standby", `MTC_ADDR_SYNC, 32'he0);
      chk("count_enable standby", 32'h00, count_enable);
      $display("t_regs done");
   endtask
   task automatic t_clear;
      apb(1'b1, `MTC_ADDR_SYNC, 32'h03);
      clear_req <= 5'h01;
      @(posedge pclk);
      clear_req <= 5'h04;
      @(negedge pclk);
      chk("joint clear", 32'h03, clear_out);
      @(posedge pclk);
      clear_req <= 5'h00;
      @(negedge pclk);
      chk("own clear", 32'h04, clear_out);
      @(posedge pclk);
      $display("t_clear done");
   endtask
   task automatic t_pwm;
      apb(1'b1, `MTC_ADDR_MODE, 32'h11);
      chk("pwm enable", 32'h11, timer_pin_a_oe);
      match_a <= 5'h11;
      @(posedge pclk);
      match_a <= 5'h00;
      @(posedge pclk);
      chk("pwm set", 32'h11, timer_pin_a);
      match_b <= 5'h01;
      @(posedge pclk);
      match_b <= 5'h00;
      @(posedge pclk);
      chk("pwm clear", 32'h10, timer_pin_a);
      apb(1'b1, `MTC_ADDR_COMB, 32'h20);
      rdchk("comb code", `MTC_ADDR_COMB, 32'h20);
      apb(1'b1, `MTC_ADDR_MODE, 32'h18);
      match_a <= 5'h18;
      @(posedge pclk);
      match_a <= 5'h00;
      @(posedge pclk);
      chk("comb override", 32'h10, timer_pin_a);
      apb(1'b1, `MTC_ADDR_COMB, 32'h00);
      $display("t_pwm done");
   endtask
   task automatic t_quad;
      apb(1'b1, `MTC_ADDR_RUN, 32'h04);
      apb(1'b1, `MTC_ADDR_MODE, 32'h40);
      seen <= 1'b0;
      mtc_enc_i.step(1'b0);
      chk("count down", 32'hffff, counter_ch2);
      chk("underflow flag", 32'h1, seen);
      seen <= 1'b0;
      repeat (4) mtc_enc_i.step(1'b1);
      chk("count up", 32'h3, counter_ch2);
      chk("overflow flag", 32'h1, seen);
      ch_tick <= 5'h1f;
      repeat (3) @(posedge pclk);
      ch_tick <= 5'h00;
      chk("tick ignored", 32'h3, counter_ch2);
      chk("irq masked", 32'h0, irq);
      apb(1'b1, `MTC_ADDR_MASK, 32'h3);
      chk("irq", 32'h1, irq);
      rdchk("status", `MTC_ADDR_STAT, 32'h3);
      chk("irq cleared", 32'h0, irq);
      apb(1'b1, `MTC_ADDR_MASK, 32'h0);
      apb(1'b1, `MTC_ADDR_MODE, 32'h60);
      seen <= 1'b0;
      repeat (4) mtc_enc_i.step(1'b0);
      chk("count wrap", 32'hffff, counter_ch2);
      chk("no underflow flag", 32'h0, seen);
      $display("t_quad done");
   endtask
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_clear;
      t_pwm;
      t_quad;
      test_done;
   end
   initial begin
      #40000;
      failures++;
      test_done;
   end
endmodule
`default_nettype wire
